// ==== hdl/tofh_defines.vh ====
// Constants for the ranging sensor bus controller
`ifndef TOFH_DEFINES_VH
`define TOFH_DEFINES_VH
`define TOFH_ADDR_WR      8'h52
`define TOFH_ADDR_RD      8'h53
`define TOFH_CLK_NS       100
`define TOFH_BIT_NS       1000
`define TOFH_QTR_CYC      ((`TOFH_BIT_NS / 4 + `TOFH_CLK_NS - 1) / `TOFH_CLK_NS)
`define TOFH_BOOT_NS      1200000
`define TOFH_BOOT_CYC     ((`TOFH_BOOT_NS + `TOFH_CLK_NS - 1) / `TOFH_CLK_NS)
`define TOFH_OP_WR        2'h0
`define TOFH_OP_RD        2'h1
`define TOFH_OP_RD_NOIDX  2'h2
`endif

// ==== hdl/tofh_host.v ====
// Bus controller that drives the ranging sensor over its serial pins
// Behaviour
// - Address byte 0x52 writes, 0x53 reads
// - Sample SDA on SCL rise, hold while high
// - Start and stop: SDA edges while SCL high
// - Eight bits MSB first, then acknowledge
// - Open with start, close with stop
// - Write sends 16-bit register index
// - Receiver acknowledges every byte except the last byte of a read
// - Controller ends read with not-acknowledge
// - Burst data without resending index
// - Open-drain lines, released reads high
// - Controller makes clock, up to 1 Mbit/s
// - Prefer interrupt pin over polling
// - Raise shutdown only with supply on
// - Multibyte accesses MSB at lowest address
`timescale 1ns/1ns
`default_nettype none
`include "tofh_defines.vh"
module tofh_host #(
  parameter BOOT_CYC = `TOFH_BOOT_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        supply_on,
  input  wire        sensor_enable,
  output reg         shutdown_n_input,
  output wire        sensor_ready,
  input  wire        result_ready_irq_pin,
  output wire        result_pending,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [1:0]  cmd_op,
  input  wire [15:0] cmd_index,
  input  wire [2:0]  cmd_len,
  input  wire [31:0] cmd_wdata,
  output reg  [31:0] rsp_rdata,
  output reg         rsp_valid,
  output reg         rsp_nack,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe
);
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_START = 10'h002;
  localparam [9:0] S_BIT   = 10'h004;
  localparam [9:0] S_ACK   = 10'h008;
  localparam [9:0] S_STOP  = 10'h010;
  localparam [9:0] S_RSTRT = 10'h020;
  localparam [9:0] S_DONE  = 10'h040;
  localparam [9:0] S_OFF   = 10'h080;
  localparam [9:0] S_BOOT  = 10'h100;
  localparam [9:0] S_RDY   = 10'h200;
  // Last boot count, cut to the counter width
  localparam integer BOOT_LAST_I = BOOT_CYC - 1;
  localparam [17:0]  BOOT_LAST   = BOOT_LAST_I[17:0];

  wire scl_s;
  wire sda_s;
  wire irq_s;
  wire tick;
  reg  [9:0]  st_q;
  reg  [9:0]  pw_q;
  reg  [1:0]  ph_q;
  reg  [2:0]  bit_q;
  reg  [7:0]  sh_q;
  reg  [2:0]  byte_q;
  reg  [2:0]  len_q;
  reg  [1:0]  op_q;
  reg  [15:0] idx_q;
  reg  [31:0] wd_q;
  reg  [31:0] rd_q;
  reg         rx_q;
  reg         scl_lo_q;
  reg         sda_lo_q;
  reg         nack_q;
  reg  [17:0] boot_q;

  // Pin inputs pass two flip-flops
  tofh_sync u_scl (.clk(clk), .rst_n(rst_n), .d(scl_i), .q(scl_s));
  tofh_sync u_sda (.clk(clk), .rst_n(rst_n), .d(sda_i), .q(sda_s));
  tofh_sync u_irq (.clk(clk), .rst_n(rst_n), .d(result_ready_irq_pin), .q(irq_s));

  // Quarter-bit timing, 1.2 us bit period
  tofh_tick u_tick (.clk(clk), .rst_n(rst_n), .run(st_q != S_IDLE), .tick(tick));

  // Lines are only pulled low or released
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_lo_q;
  assign sda_oe = sda_lo_q;

  assign result_pending = !irq_s;
  assign sensor_ready   = (pw_q == S_RDY);
  // No command taken in the cycle the sensor is being shut down
  assign cmd_ready      = (st_q == S_IDLE) && (pw_q == S_RDY) && !rsp_valid &&
                          supply_on && sensor_enable;

  // Byte to send in the current slot
  function [7:0] tx_byte;
    input [2:0]  n;
    input [1:0]  op;
    input [15:0] idx;
    input [31:0] wd;
    input [2:0]  len;
    reg   [4:0]  sel;
    begin
      sel = 5'h00;
      if (n == 3'h0) begin
        tx_byte = (op == `TOFH_OP_RD_NOIDX) ? `TOFH_ADDR_RD : `TOFH_ADDR_WR;
      end else if (n == 3'h1) begin
        tx_byte = idx[15:8];
      end else if (n == 3'h2) begin
        tx_byte = idx[7:0];
      end else begin
        sel = {2'b00, len - 3'h1} << 3; // len counts bytes still to send
        tx_byte = wd[sel +: 8];
      end
    end
  endfunction

  // Power sequence: shutdown low until supply, then boot wait
  always @(posedge clk) begin
    if (!rst_n) begin
      pw_q             <= S_OFF;
      shutdown_n_input <= 1'b0;
      boot_q           <= 18'h00000;
    end else begin
      case (pw_q)
        S_OFF: begin
          shutdown_n_input <= 1'b0;
          boot_q           <= 18'h00000;
          if (supply_on && sensor_enable) begin
            pw_q             <= S_BOOT;
            shutdown_n_input <= 1'b1;
          end
        end
        S_BOOT: begin
          boot_q <= boot_q + 18'h00001;
          if (!supply_on || !sensor_enable) begin
            pw_q             <= S_OFF;
            shutdown_n_input <= 1'b0;
          end else if (boot_q == BOOT_LAST) begin
            pw_q <= S_RDY;
          end
        end
        S_RDY: begin
          if ((!supply_on || !sensor_enable) && st_q == S_IDLE) begin
            pw_q             <= S_OFF;
            shutdown_n_input <= 1'b0;
          end
        end
        default: begin
          pw_q <= S_OFF;
        end
      endcase
    end
  end

  // Transfer engine, four quarter phases per bit
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= S_IDLE;
      ph_q      <= 2'h0;
      bit_q     <= 3'h0;
      sh_q      <= 8'h00;
      byte_q    <= 3'h0;
      len_q     <= 3'h0;
      op_q      <= 2'h0;
      idx_q     <= 16'h0000;
      wd_q      <= 32'h00000000;
      rd_q      <= 32'h00000000;
      rx_q      <= 1'b0;
      scl_lo_q  <= 1'b0;
      sda_lo_q  <= 1'b0;
      nack_q    <= 1'b0;
      rsp_rdata <= 32'h00000000;
      rsp_valid <= 1'b0;
      rsp_nack  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        S_IDLE: begin
          scl_lo_q <= 1'b0;
          sda_lo_q <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            op_q   <= cmd_op;
            idx_q  <= cmd_index;
            len_q  <= (cmd_len == 3'h0) ? 3'h1 : cmd_len;
            wd_q   <= cmd_wdata;
            rd_q   <= 32'h00000000;
            nack_q <= 1'b0;
            byte_q <= 3'h0;
            ph_q   <= 2'h0;
            st_q   <= S_START;
          end
        end
        S_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h1) begin
            sda_lo_q <= 1'b1;
          end else if (ph_q == 2'h3) begin
            scl_lo_q <= 1'b1;
            rx_q     <= (byte_q != 3'h0) && (op_q != `TOFH_OP_WR);
            sh_q     <= tx_byte(byte_q, op_q, idx_q, wd_q, len_q);
            bit_q    <= 3'h7;
            st_q     <= S_BIT;
          end
        end
        S_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_lo_q <= !rx_q && !sh_q[7];
            2'h1: scl_lo_q <= 1'b0;
            2'h2: if (scl_s) begin
              sh_q <= {sh_q[6:0], sda_s};
            end else begin
              ph_q <= ph_q; // Clock stretched by target
            end
            default: begin
              scl_lo_q <= 1'b1;
              bit_q    <= bit_q - 3'h1;
              if (bit_q == 3'h0) st_q <= S_ACK;
            end
          endcase
        end
        S_ACK: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_lo_q <= rx_q && (len_q != 3'h1);
            2'h1: scl_lo_q <= 1'b0;
            2'h2: if (!scl_s) begin
              ph_q <= ph_q;
            end else if (!rx_q) begin
              nack_q <= sda_s;
            end
            default: begin
              scl_lo_q <= 1'b1;
              if (rx_q) begin
                rd_q  <= {rd_q[23:0], sh_q};
                len_q <= len_q - 3'h1;
              end else if (byte_q > 3'h2) begin
                len_q <= len_q - 3'h1;
              end
              byte_q <= byte_q + 3'h1;
              if (nack_q || (rx_q && len_q == 3'h1) ||
                  (!rx_q && byte_q > 3'h2 && len_q == 3'h1)) begin
                st_q <= S_STOP;
              end else if (op_q == `TOFH_OP_RD && byte_q == 3'h2) begin
                st_q <= S_RSTRT;
              end else begin
                rx_q  <= (op_q != `TOFH_OP_WR) && (byte_q != 3'h1 || op_q == `TOFH_OP_RD_NOIDX)
                         && !(op_q == `TOFH_OP_RD && byte_q < 3'h3);
                // Bytes left after this one once data has started
                sh_q  <= tx_byte(byte_q + 3'h1, op_q, idx_q, wd_q,
                                 (byte_q > 3'h2) ? len_q - 3'h1 : len_q);
                bit_q <= 3'h7;
                st_q  <= S_BIT;
              end
            end
          endcase
        end
        S_RSTRT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_lo_q <= 1'b0;
            2'h1: scl_lo_q <= 1'b0;
            2'h2: sda_lo_q <= scl_s;
            default: begin
              scl_lo_q <= 1'b1;
              rx_q     <= 1'b0;
              sh_q     <= `TOFH_ADDR_RD;
              bit_q    <= 3'h7;
              op_q     <= `TOFH_OP_RD_NOIDX;
              byte_q   <= 3'h0;
              st_q     <= S_BIT;
            end
          endcase
        end
        S_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_lo_q <= 1'b1;
            2'h1: scl_lo_q <= 1'b0;
            2'h2: sda_lo_q <= !scl_s;
            default: st_q <= S_DONE;
          endcase
        end
        S_DONE: begin
          rsp_rdata <= rd_q;
          rsp_nack  <= nack_q;
          rsp_valid <= 1'b1;
          st_q      <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // tofh_host
`default_nettype wire

// ==== hdl/tofh_sync.v ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module tofh_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire q
);
  reg s1_q;
  reg s2_q;

  // Stage one feeds only stage two
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // tofh_sync
`default_nettype wire

// ==== hdl/tofh_tick.v ====
// Quarter-bit tick generator for bus timing
`timescale 1ns/1ns
`default_nettype none
`include "tofh_defines.vh"
module tofh_tick (
  input  wire clk,
  input  wire rst_n,
  input  wire run,
  output wire tick
);
  // Last count of a quarter bit, cut to the counter width
  localparam integer QTR_LAST_I = `TOFH_QTR_CYC - 1;
  localparam [7:0]   QTR_LAST   = QTR_LAST_I[7:0];

  reg [7:0] cnt_q;

  // Counts quarter bit periods while running
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == QTR_LAST) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign tick = run && (cnt_q == QTR_LAST);
endmodule // tofh_tick
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the ranging sensor bus controller
`timescale 1ns/1ns
`default_nettype none
`include "tofh_defines.vh"
module tb_top;
  logic        clk = 0, rst_n = 0, sup = 0, en = 0, cv = 0, nk = 0, rz = 0;
  logic [1:0]  op = 0;
  logic [15:0] ix = 0, a;
  logic [2:0]  ln = 1;
  logic [31:0] wd = 0, d, d2, rdat;
  logic        shn, srdy, irq, pnd, crdy, rv, rnk, scl_oe, sda_oe, t_oe;
  logic [33:0] exp_q [$];
  logic [33:0] e;
  integer      bad_count = 0, tests_run = 0, cyc = 0, i;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe | t_oe);
  tofh_host #(.BOOT_CYC(20)) i_tofh_host (.clk(clk), .rst_n(rst_n), .supply_on(sup),
    .sensor_enable(en), .shutdown_n_input(shn), .sensor_ready(srdy),
    .result_ready_irq_pin(irq), .result_pending(pnd), .cmd_valid(cv), .cmd_ready(crdy),
    .cmd_op(op), .cmd_index(ix), .cmd_len(ln), .cmd_wdata(wd), .rsp_rdata(rdat),
    .rsp_valid(rv), .rsp_nack(rnk), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe));
  tofh_sensor i_tofh_sensor (.scl(scl), .sda(sda), .shut_n(shn), .nack(nk), .raise(rz),
    .sda_oe(t_oe), .irq_n(irq));
  always #50 clk = ~clk;
  // Cycle ceiling against a hung transfer
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  // Compare each response with the oldest expected one
  always @(negedge clk) if (rv === 1'b1) begin
    e = exp_q.pop_front();
    tests_run = tests_run + 1;
    if (rnk !== e[32] || (e[33] && rdat !== e[31:0])) begin
      bad_count = bad_count + 1;
      $display("BAD %0t rsp %h nack %b", $time, rdat, rnk);
    end
  end
  function [31:0] msk(input [2:0] n, input [31:0] v);
    msk = n[2] ? v : v & ((32'h1 << {n, 3'h0}) - 32'h1);
  endfunction
  task ck(input logic ok);
    tests_run = tests_run + 1;
    if (ok !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("BAD %0t pin level", $time);
    end
  endtask
  task cmd(input [1:0] o, input [15:0] x, input [2:0] n, input [31:0] v, input [33:0] xe);
    exp_q.push_back(xe);
    @(posedge clk);
    op <= o;
    ix <= x;
    ln <= n;
    wd <= v;
    cv <= 1;
    do @(negedge clk); while (crdy !== 1'b1);
    @(posedge clk);
    cv <= 0;
    while (exp_q.size() > 0) @(posedge clk);
  endtask
  task boot_wait;
    do @(negedge clk); while (srdy !== 1'b1 && cyc < 50000);
  endtask
  task test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    i = $urandom(30);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    sup <= 1;
    en <= 1;
    boot_wait;
    ck(shn === 1'b1 && srdy === 1'b1);
    for (i = 1; i < 5; i = i + 1) begin
      a = 16'h0100 + 16'($urandom % 200);
      d = $urandom;
      cmd(`TOFH_OP_WR, a, i[2:0], d, 34'h0);
      cmd(`TOFH_OP_RD, a, i[2:0], 32'h0, {2'b10, msk(i[2:0], d)});
    end
    d2 = $urandom;
    cmd(`TOFH_OP_WR, a, 3'h4, d, 34'h0);
    cmd(`TOFH_OP_WR, a + 16'h4, 3'h4, d2, 34'h0);
    cmd(`TOFH_OP_RD, a, 3'h4, 32'h0, {2'b10, d});
    cmd(`TOFH_OP_RD_NOIDX, a, 3'h4, 32'h0, {2'b10, d2});
    nk <= 1;
    cmd(`TOFH_OP_WR, a, 3'h2, d, {2'b01, 32'h0});
    cmd(`TOFH_OP_RD_NOIDX, a, 3'h1, 32'h0, {2'b01, 32'h0});
    nk <= 0;
    rz <= 1;
    repeat (6) @(negedge clk);
    ck(pnd === 1'b1);
    cmd(`TOFH_OP_RD, a, 3'h1, 32'h0, {2'b10, 24'h0, d[31:24]});
    ck(pnd === 1'b1);
    cmd(`TOFH_OP_RD_NOIDX, a, 3'h0, 32'h0, {2'b10, 24'h0, d[23:16]});
    cmd(`TOFH_OP_WR, 16'h0086, 3'h1, d, 34'h0);
    repeat (6) @(negedge clk);
    ck(pnd === 1'b0);
    @(posedge clk);
    rz <= 0;
    en <= 0;
    repeat (4) @(negedge clk);
    ck(shn === 1'b0 && srdy === 1'b0 && crdy === 1'b0);
    @(posedge clk);
    sup <= 0;
    en <= 1;
    repeat (30) @(negedge clk);
    ck(shn === 1'b0);
    @(posedge clk);
    sup <= 1;
    boot_wait;
    ck(srdy === 1'b1);
    test_done;
  end
endmodule // tb_top
`default_nettype wire

// ==== verification/tofh_host_chk.sv ====
// Protocol checker bound to the ranging sensor bus controller
`timescale 1ns/1ns
`default_nettype none
module tofh_host_chk #(
  parameter BOOT_CYC = 20
) (
  input wire clk,
  input wire rst_n,
  input wire supply_on,
  input wire shutdown_n_input,
  input wire sensor_ready,
  input wire result_ready_irq_pin,
  input wire result_pending,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire rsp_valid,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe
);
  logic [15:0] cnt_q;
  wire  [15:0] cnt_d = (rst_n && shutdown_n_input) ? cnt_q + 16'h1 : 16'h0;
  // Cycles since the sensor left shutdown
  always @(posedge clk) cnt_q <= cnt_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_lines_free: assert property ($rose(rst_n) |-> !sda_oe && !scl_oe && !rsp_valid)
    else $error("lines held after reset");
  a_pull_low_only: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("line driven high");
  a_boot_wait: assert property ($rose(sensor_ready) |-> cnt_q >= BOOT_CYC - 2 && cnt_q <= BOOT_CYC + 2)
    else $error("boot wait length wrong");
  a_wake_supply: assert property ($rose(shutdown_n_input) |-> $past(supply_on))
    else $error("wake without supply");
  a_start_first: assert property (cmd_valid && cmd_ready |=> !scl_oe [*4] ##[1:12] sda_oe && !scl_oe)
    else $error("no start after command");
  a_stop_last: assert property (rsp_valid |-> !sda_oe && !scl_oe && !$past(scl_oe))
    else $error("response before stop");
  a_scl_low_min: assert property ($rose(scl_oe) |-> scl_oe [*3])
    else $error("clock low too short");
  a_pend_set: assert property (!result_ready_irq_pin [*4] |-> result_pending)
    else $error("pending not raised");
  a_pend_clear: assert property (result_ready_irq_pin [*4] |-> !result_pending)
    else $error("pending not cleared");
  c_boot: cover property ($rose(sensor_ready));
  c_rsp: cover property (rsp_valid);
  c_irq: cover property ($rose(result_pending));
endmodule // tofh_host_chk
bind tofh_host tofh_host_chk #(.BOOT_CYC(BOOT_CYC)) i_chk (.clk(clk), .rst_n(rst_n),
  .supply_on(supply_on), .shutdown_n_input(shutdown_n_input), .sensor_ready(sensor_ready),
  .result_ready_irq_pin(result_ready_irq_pin), .result_pending(result_pending),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ==== verification/tofh_sensor.sv ====
// Behavioural ranging sensor: serial target, registers, interrupt pin
`timescale 1ns/1ns
`default_nettype none
module tofh_sensor #(
  parameter [15:0] CLR_IDX = 16'h0086
) (
  input  wire  scl,
  input  wire  sda,
  input  wire  shut_n,
  input  wire  nack,
  input  wire  raise,
  output logic sda_oe,
  output wire  irq_n
);
  logic [7:0]  mem [0:255];
  logic [7:0]  sh;
  logic [15:0] idx;
  logic        act = 0, rd = 0, pend = 0;
  integer      bc = 0, n = 0;
  initial sda_oe = 1'b0;
  // Start: data falls with clock high, ignored in standby
  always @(negedge sda) if (scl && shut_n) begin
    act = 1;
    rd = 0;
    bc = -1;
    n = 0;
  end
  // Stop: data rises with clock high
  always @(posedge sda) if (scl) begin
    act = 0;
    sda_oe = 0;
  end
  // Sample on the rising clock edge
  always @(posedge scl) if (act) begin
    if (!rd && bc < 8) sh = {sh[6:0], sda};
    if (rd && bc == 8 && sda) act = 0;
  end
  // Count bits, acknowledge and drive on the falling clock edge
  always @(negedge scl) if (act) begin
    bc = bc + 1;
    sda_oe = 0;
    if (bc == 8 && !rd) begin
      if (n == 0) begin
        act = sh[7:1] == 7'h29 && !nack;
        rd = sh[0];
      end else if (n < 3) idx = {idx[7:0], sh};
      else begin
        mem[idx[7:0]] = sh;
        if (idx == CLR_IDX) pend = 0;
        idx = idx + 16'h1;
      end
      sda_oe = act;
    end
    if (bc == 9) begin
      bc = 0;
      n = n + 1;
      if (rd) sh = mem[idx[7:0]];
      if (rd) idx = idx + 16'h1;
    end
    if (rd && act && bc < 8) sda_oe = !sh[7 - bc];
  end
  // Result ready: pin held low until the clearing write
  always @(posedge raise) pend = 1;
  assign irq_n = !pend;
endmodule // tofh_sensor
`default_nettype wire
